// File: rcc_pkg.sv
package rcc_pkg;
    localparam logic [31:0] ADDR_CONTROL_TWO = 32'h40000200;
    localparam logic [31:0] ADDR_IRQ_STATUS = 32'h40000300;
    localparam logic [31:0] ADDR_IRQ_CLEAR = 32'h40000304;
    localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h40000308;
    localparam int TX_START_HI = 31;
    localparam int TX_START_LO = 22;
    localparam int WAKEUP_STAT_BIT = 20;
    localparam int PRIO_SRC_BIT = 17;
    localparam int TX_MODE_BIT = 16;
    localparam int TX_SRC_BIT = 15;
    localparam int CLK_FREQ_HI = 14;
    localparam int CLK_FREQ_LO = 9;
    localparam int PWRDN_ALLOW_BIT = 8;
    localparam int SLOW_MON_BIT = 7;
    localparam int CLK_STAT_BIT = 6;
    localparam int DIAG_SEL_HI = 5;
    localparam int DIAG_SEL_LO = 4;
    localparam int DIAG_OVR_BIT = 3;
    localparam logic [9:0] TX_START_RESET = 10'h000;
    localparam logic [5:0] CLK_FREQ_RESET = 6'h00;
    localparam logic [1:0] DIAG_SEL_RESET = 2'h0;
    localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
    localparam logic [3:0] PWRDN_SLOW_TICKS = 4'h2;
    localparam int IRQ_WAKEUP = 0;
    localparam int IRQ_PWRDN = 1;
    localparam int IRQ_SLOW_EDGE = 2;
    localparam int IRQ_TRANSACTION = 3;
    typedef enum logic [1:0] {
        DIAG_SLOW_CLK = 2'b00,
        DIAG_RUN_32K = 2'b01,
        DIAG_CPU_SLEEP = 2'b10,
        DIAG_CORE_SLEEP = 2'b11
    } rcc_diag_e;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_ARMED = 2'b01,
        TX_WAIT_EN = 2'b10,
        TX_ACTIVE = 2'b11
    } rcc_tx_e;
endpackage

// File: rcc_edge_sync.sv
`timescale 1ns/10ps
// three-stage synchroniser; a change counts once stages two and three agree
module rcc_edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async,
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic [2:0] pipe;
        logic level;
    } rcc_sync_s;
    rcc_sync_s st;
    rcc_sync_s next_st;
    always_comb begin
        next_st = st;
        next_st.pipe = {st.pipe[1:0], async};
        if (st.pipe[1] == st.pipe[2]) begin
            next_st.level = st.pipe[2];
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign level = st.level;
    assign rise = next_st.level & ~st.level;
endmodule

// File: rcc_control_status.sv
`timescale 1ns/10ps
module rcc_control_status (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdata,
    output logic irq,
    input wire logic lowPowerClk,
    input wire logic timerSlowReset,
    input wire logic wakeupIrqRaise,
    input wire logic radioPoweredUp,
    input wire logic deepSleepRequest,
    input wire logic sleepExitInterrupt,
    input wire logic coreOnMasterClk,
    input wire logic [3:0] staticPriority,
    input wire logic [3:0] dynamicPriority,
    input wire logic priorityValid,
    input wire logic eventInProcess,
    input wire logic txRxEnable,
    input wire logic [9:0] fineCounter,
    output logic [3:0] arbiterPriority,
    output logic radioTransactionSignal,
    input wire logic [31:0] cpuIrqLines,
    input wire logic runningAt32k,
    input wire logic cpuDeepSleep,
    input wire logic coreSleepStatus,
    input wire logic padLatchEnIn,
    input wire logic [1:0] padDirOutIn,
    input wire logic [1:0] padDataIn,
    output logic padLatchEn,
    output logic [1:0] padDirOut,
    output logic [1:0] padData
);
    typedef struct packed {
        logic [9:0] txStart;
        logic wakeupStat;
        logic wakePending;
        logic prioSrc;
        logic txMode;
        logic txSrc;
        logic [5:0] clkFreq;
        logic pwrdnAllow;
        logic [3:0] pwrdnCount;
        logic pwrdnRun;
        logic slowMon;
        logic clkStat;
        logic [1:0] diagSel;
        logic diagOvr;
        rcc_pkg::rcc_tx_e txState;
        logic txLow;
        logic [3:0] lastPrio;
        logic [3:0] prioOut;
        logic txSig;
        logic [3:0] irqStatus;
        logic [3:0] irqEnable;
        logic [31:0] rdata;
        logic [1:0] padData;
    } rcc_state_s;

    rcc_state_s st;
    rcc_state_s next_st;
    logic slowLevel;
    logic slowRise;
    logic [3:0] events;
    logic [3:0] prioSel;
    logic txRxRise;
    logic prevTxRx;
    logic wrCtl;
    logic wrClr;
    logic wrEn;
    logic startHit;
    logic [31:0] ctlWord;

    rcc_edge_sync slowSync (
        .clk(clk),
        .rst_n(rst_n),
        .async(lowPowerClk),
        .level(slowLevel),
        .rise(slowRise)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prevTxRx <= 1'b0;
        end else begin
            prevTxRx <= txRxEnable;
        end
    end

    assign txRxRise = txRxEnable & ~prevTxRx;
    assign wrCtl = regWrite && regAddr == rcc_pkg::ADDR_CONTROL_TWO;
    assign wrClr = regWrite && regAddr == rcc_pkg::ADDR_IRQ_CLEAR;
    assign wrEn = regWrite && regAddr == rcc_pkg::ADDR_IRQ_ENABLE;
    assign startHit = fineCounter == st.txStart;
    assign prioSel = st.prioSrc ? dynamicPriority : staticPriority;

    always_comb begin
        ctlWord = '0;
        ctlWord[rcc_pkg::TX_START_HI:rcc_pkg::TX_START_LO] = st.txStart;
        ctlWord[rcc_pkg::WAKEUP_STAT_BIT] = st.wakeupStat;
        ctlWord[rcc_pkg::PRIO_SRC_BIT] = st.prioSrc;
        ctlWord[rcc_pkg::TX_MODE_BIT] = st.txMode;
        ctlWord[rcc_pkg::TX_SRC_BIT] = st.txSrc;
        ctlWord[rcc_pkg::CLK_FREQ_HI:rcc_pkg::CLK_FREQ_LO] = st.clkFreq;
        ctlWord[rcc_pkg::PWRDN_ALLOW_BIT] = st.pwrdnAllow;
        ctlWord[rcc_pkg::SLOW_MON_BIT] = st.slowMon;
        ctlWord[rcc_pkg::CLK_STAT_BIT] = st.clkStat;
        ctlWord[rcc_pkg::DIAG_SEL_HI:rcc_pkg::DIAG_SEL_LO] = st.diagSel;
        ctlWord[rcc_pkg::DIAG_OVR_BIT] = st.diagOvr;
    end

    always_comb begin
        next_st = st;
        events = '0;
        next_st.clkStat = coreOnMasterClk;
        // wakeup: set by raise, cleared after powerup and one slow tick
        if (wakeupIrqRaise) begin
            next_st.wakeupStat = 1'b1;
            next_st.wakePending = 1'b0;
            events[rcc_pkg::IRQ_WAKEUP] = 1'b1;
        end else if (st.wakeupStat && radioPoweredUp && !st.wakePending) begin
            next_st.wakePending = 1'b1;
        end else if (st.wakePending && slowRise) begin
            next_st.wakeupStat = 1'b0;
            next_st.wakePending = 1'b0;
        end
        // power-down allowed: slow-clock timed sequence
        if (sleepExitInterrupt) begin
            next_st.pwrdnAllow = 1'b0;
            next_st.pwrdnRun = 1'b0;
            next_st.pwrdnCount = '0;
        end else if (deepSleepRequest && !st.pwrdnRun && !st.pwrdnAllow) begin
            next_st.pwrdnRun = 1'b1;
            next_st.pwrdnCount = '0;
        end else if (st.pwrdnRun && slowRise) begin
            if (st.pwrdnCount == rcc_pkg::PWRDN_SLOW_TICKS - 4'h1) begin
                next_st.pwrdnAllow = 1'b1;
                next_st.pwrdnRun = 1'b0;
                events[rcc_pkg::IRQ_PWRDN] = 1'b1;
            end else begin
                next_st.pwrdnCount = st.pwrdnCount + 4'h1;
            end
        end
        // control writes; read-only bits untouched
        if (wrCtl) begin
            next_st.txStart = regWdata[rcc_pkg::TX_START_HI:rcc_pkg::TX_START_LO];
            next_st.prioSrc = regWdata[rcc_pkg::PRIO_SRC_BIT];
            next_st.txMode = regWdata[rcc_pkg::TX_MODE_BIT];
            next_st.txSrc = regWdata[rcc_pkg::TX_SRC_BIT];
            // field is held as written; setting it late is software's fault
            next_st.clkFreq =
                regWdata[rcc_pkg::CLK_FREQ_HI:rcc_pkg::CLK_FREQ_LO];
            next_st.diagSel = regWdata[rcc_pkg::DIAG_SEL_HI:rcc_pkg::DIAG_SEL_LO];
            next_st.diagOvr = regWdata[rcc_pkg::DIAG_OVR_BIT];
            if (!regWdata[rcc_pkg::SLOW_MON_BIT]) begin
                next_st.slowMon = 1'b0;
            end
        end
        // set wins over a same-cycle software clear
        if (slowRise && !timerSlowReset) begin
            next_st.slowMon = 1'b1;
            events[rcc_pkg::IRQ_SLOW_EDGE] = 1'b1;
        end
        // transaction signal towards the arbiter
        next_st.prioOut = prioSel;
        next_st.lastPrio = prioSel;
        next_st.txLow = 1'b0;
        unique case (st.txState)
            rcc_pkg::TX_IDLE: begin
                if (eventInProcess) begin
                    next_st.txState = rcc_pkg::TX_ARMED;
                end
            end
            rcc_pkg::TX_ARMED: begin
                if (!eventInProcess) begin
                    next_st.txState = rcc_pkg::TX_IDLE;
                end else if (startHit) begin
                    if (st.txSrc ? eventInProcess : priorityValid) begin
                        next_st.txState = rcc_pkg::TX_ACTIVE;
                        events[rcc_pkg::IRQ_TRANSACTION] = 1'b1;
                    end else begin
                        next_st.txState = rcc_pkg::TX_WAIT_EN;
                    end
                end
            end
            rcc_pkg::TX_WAIT_EN: begin
                if (!eventInProcess) begin
                    next_st.txState = rcc_pkg::TX_IDLE;
                end else if (txRxRise) begin
                    next_st.txState = rcc_pkg::TX_ACTIVE;
                    events[rcc_pkg::IRQ_TRANSACTION] = 1'b1;
                end
            end
            rcc_pkg::TX_ACTIVE: begin
                if (!eventInProcess) begin
                    next_st.txState = rcc_pkg::TX_IDLE;
                end else if (st.txMode && prioSel != st.lastPrio) begin
                    next_st.txLow = 1'b1;
                end
            end
        endcase
        // mode 0 keeps the level steady through the event
        next_st.txSig = next_st.txState == rcc_pkg::TX_ACTIVE
            && !next_st.txLow;
        // interrupt status: set wins over clear
        next_st.irqStatus = (st.irqStatus & ~(wrClr ? regWdata[3:0] : 4'h0))
            | events;
        if (wrEn) begin
            next_st.irqEnable = regWdata[3:0];
        end
        // read data, one cycle after the strobe
        next_st.rdata = '0;
        if (regRead) begin
            if (regAddr == rcc_pkg::ADDR_CONTROL_TWO) begin
                next_st.rdata = ctlWord;
            end else if (regAddr == rcc_pkg::ADDR_IRQ_STATUS) begin
                next_st.rdata = {28'h0000000, st.irqStatus};
            end else if (regAddr == rcc_pkg::ADDR_IRQ_ENABLE) begin
                next_st.rdata = {28'h0000000, st.irqEnable};
            end
        end
        // diagnostic pins
        next_st.padData[0] = st.diagOvr ? |cpuIrqLines : padDataIn[0];
        if (st.diagOvr) begin
            unique case (rcc_pkg::rcc_diag_e'(st.diagSel))
                rcc_pkg::DIAG_SLOW_CLK: next_st.padData[1] = slowLevel;
                rcc_pkg::DIAG_RUN_32K: next_st.padData[1] = runningAt32k;
                rcc_pkg::DIAG_CPU_SLEEP: next_st.padData[1] = cpuDeepSleep;
                rcc_pkg::DIAG_CORE_SLEEP: next_st.padData[1] = coreSleepStatus;
            endcase
        end else begin
            next_st.padData[1] = padDataIn[1];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st <= '0;
            st.txStart <= rcc_pkg::TX_START_RESET;
            st.clkFreq <= rcc_pkg::CLK_FREQ_RESET;
            st.diagSel <= rcc_pkg::DIAG_SEL_RESET;
            st.irqEnable <= rcc_pkg::IRQ_ENABLE_RESET;
            st.txState <= rcc_pkg::TX_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign regRdata = st.rdata;
    assign irq = |(st.irqStatus & st.irqEnable);
    assign arbiterPriority = st.prioOut;
    assign radioTransactionSignal = st.txSig;
    // override holds even in system power-down: no gating by sleep state
    assign padLatchEn = st.diagOvr ? 1'b1 : padLatchEnIn;
    assign padDirOut = st.diagOvr ? 2'b11 : padDirOutIn;
    assign padData = st.padData;
endmodule

// File: rcc_control_status_monitor.sv
`timescale 1ns/10ps
module rcc_control_status_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [31:0] regAddr,
    input wire logic regRead,
    input wire logic [31:0] regRdata,
    input wire logic coreOnMasterClk,
    input wire logic [3:0] staticPriority,
    input wire logic [3:0] dynamicPriority,
    input wire logic [3:0] arbiterPriority,
    input wire logic eventInProcess,
    input wire logic radioTransactionSignal,
    input wire logic [31:0] cpuIrqLines,
    input wire logic padLatchEnIn,
    input wire logic padLatchEn,
    input wire logic [1:0] padDirOut,
    input wire logic [1:0] padData
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // override only visible while the pass-through latch enable is low
    logic forced;
    assign forced = padLatchEn && !padLatchEnIn;
    a_read_idle: assert property (
        !$past(regRead) |-> regRdata == 32'h0)
        else $error("read data outside read slot");
    a_clk_stat: assert property (
        $past(rst_n, 2) && $past(regRead && regAddr ==
        rcc_pkg::ADDR_CONTROL_TWO) |-> regRdata[6] ==
        $past(coreOnMasterClk, 2)) else $error("clock status wrong");
    a_pad_forced: assert property (
        padLatchEn != padLatchEnIn |-> padLatchEn && padDirOut == 2'h3)
        else $error("pads not forced to output");
    a_pad_irq_or: assert property (
        $past(forced) |-> padData[0] == $past(|cpuIrqLines))
        else $error("first pin not irq or");
    a_prio_pick: assert property (
        $past(rst_n) |-> arbiterPriority == $past(staticPriority) ||
        arbiterPriority == $past(dynamicPriority)) else $error("bad prio");
    a_tx_in_event: assert property (
        $rose(radioTransactionSignal) |-> $past(eventInProcess))
        else $error("transaction outside event");
    a_tx_end: assert property (
        !eventInProcess |=> !radioTransactionSignal)
        else $error("transaction held after event");
    a_pulse_single: assert property (
        $fell(radioTransactionSignal) && eventInProcess &&
        $past(eventInProcess) |=> radioTransactionSignal)
        else $error("low pulse longer than one cycle");
    c_tx_rise: cover property ($rose(radioTransactionSignal));
    c_pulse: cover property ($fell(radioTransactionSignal) && eventInProcess);
    c_forced: cover property (forced && padData[0]);
endmodule
bind rcc_control_status rcc_control_status_monitor u_mon (
    .clk(clk),
    .rst_n(rst_n),
    .regAddr(regAddr),
    .regRead(regRead),
    .regRdata(regRdata),
    .coreOnMasterClk(coreOnMasterClk),
    .staticPriority(staticPriority),
    .dynamicPriority(dynamicPriority),
    .arbiterPriority(arbiterPriority),
    .eventInProcess(eventInProcess),
    .radioTransactionSignal(radioTransactionSignal),
    .cpuIrqLines(cpuIrqLines),
    .padLatchEnIn(padLatchEnIn),
    .padLatchEn(padLatchEn),
    .padDirOut(padDirOut),
    .padData(padData)
);

// File: rcc_radio_model.sv
`timescale 1ns/10ps
module rcc_radio_model (
    input wire logic clk,
    input wire logic rst_n,
    output logic lowPowerClk,
    output logic [9:0] fineCounter
);
    // slow clock runs free; odd half period keeps its phase unrelated
    initial begin
        lowPowerClk = 1'h0;
        forever #2037 lowPowerClk = ~lowPowerClk;
    end
    always_ff @(posedge clk) begin
        if (!rst_n) fineCounter <= 10'h0;
        else fineCounter <= fineCounter + 10'h1;
    end
endmodule

// File: rcc_control_status_tb.sv
`timescale 1ns/10ps
module rcc_control_status_tb;
    logic clk, rst_n, regWrite, regRead, irq, lowPowerClk, found;
    logic [31:0] regAddr, regWdata, regRdata, cpuIrqLines;
    logic timerSlowReset, wakeupIrqRaise, radioPoweredUp, deepSleepRequest;
    logic sleepExitInterrupt, coreOnMasterClk, priorityValid;
    logic eventInProcess, txRxEnable, runningAt32k, cpuDeepSleep;
    logic coreSleepStatus, padLatchEnIn, padLatchEn, radioTransactionSignal;
    logic [3:0] staticPriority, dynamicPriority, arbiterPriority;
    logic [9:0] fineCounter;
    logic [1:0] padDirOutIn, padDataIn, padDirOut, padData, seen;
    int fails = 0;
    int nCompared = 0;
    int lows;
    localparam logic [31:0] CTL = rcc_pkg::ADDR_CONTROL_TWO;
    localparam logic [9:0] START = 10'h00A;
    rcc_control_status dut (.*);
    rcc_radio_model model (.clk, .rst_n, .lowPowerClk, .fineCounter);
    task automatic chk(input string what, input logic [31:0] got,
            input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'h1;
        @(posedge clk);
        regWrite <= 1'h0;
    endtask
    task automatic rdc(input logic [31:0] a, input logic [31:0] m,
            input logic [31:0] e, input string what);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'h1;
        @(posedge clk);
        regRead <= 1'h0;
        #1 chk(what, regRdata & m, e);
    endtask
    task automatic waitRise(input int n);
        found = 1'h0;
        for (int i = 0; i < n && !found; i++) begin
            @(posedge clk);
            #1 found = (radioTransactionSignal === 1'h1);
        end
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", nCompared, fails);
        if (fails == 0 && nCompared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        report_and_stop();
    end
    initial begin
        {rst_n, regWrite, regRead, wakeupIrqRaise, radioPoweredUp} = '0;
        {deepSleepRequest, sleepExitInterrupt, coreOnMasterClk} = '0;
        {priorityValid, eventInProcess, txRxEnable, runningAt32k} = '0;
        {cpuDeepSleep, coreSleepStatus, padLatchEnIn, timerSlowReset} = 4'h1;
        {regAddr, regWdata, cpuIrqLines} = '0;
        {staticPriority, dynamicPriority, padDirOutIn, padDataIn} = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        repeat (50) @(posedge clk);
        rdc(CTL, '1, 32'h0, "ctl reset");
        rdc(rcc_pkg::ADDR_IRQ_ENABLE, '1, 32'h0, "enable reset");
        wr(CTL, '1);
        rdc(CTL, '1, 32'hFFC3FE38, "ctl rw");
        rdc(32'h40000400, '1, 32'h0, "unmapped");
        for (int s = 1; s < 4; s++) begin
            wr(CTL, 32'h8 | (s << 4));
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                {coreSleepStatus, cpuDeepSleep, runningAt32k} <=
                    v ? ~3'(1 << (s - 1)) : 3'(1 << (s - 1));
                cpuIrqLines <= v ? 32'h0 : 32'h10000;
                #301 chk("diag", {padLatchEn, padDirOut, padData},
                    v ? 5'h1C : 5'h1F);
            end
        end
        wr(CTL, 32'h8);
        seen = '0;
        repeat (60) begin
            @(posedge clk);
            #1 seen = seen | {padData[1], ~padData[1]};
        end
        chk("slow diag", seen, 2'h3);
        wr(CTL, 32'h0);
        {padLatchEnIn, padDirOutIn, padDataIn} <= 5'h16;
        #301 chk("pads off", {padLatchEn, padDirOut, padData}, 5'h16);
        @(posedge clk);
        timerSlowReset <= 1'h0;
        wr(rcc_pkg::ADDR_IRQ_ENABLE, 32'h4);
        // step off the edge so the poll never races the register update
        #1;
        for (int i = 0; i < 100 && irq !== 1'h1; i++) #100;
        chk("irq slow", irq, 1'h1);
        rdc(CTL, 32'h80, 32'h80, "mon set");
        wr(CTL, 32'h0);
        rdc(CTL, 32'h80, 32'h0, "mon clr");
        wr(rcc_pkg::ADDR_IRQ_CLEAR, 32'h4);
        #1 chk("irq clr", irq, 1'h0);
        // masked: events keep landing but the line must stay low
        wr(rcc_pkg::ADDR_IRQ_ENABLE, 32'h0);
        #5001 chk("irq mask", irq, 1'h0);
        rdc(rcc_pkg::ADDR_IRQ_STATUS, 32'h4, 32'h4, "stat slow");
        @(posedge clk);
        wakeupIrqRaise <= 1'h1;
        @(posedge clk);
        wakeupIrqRaise <= 1'h0;
        #6010 rdc(CTL, 32'h100000, 32'h100000, "wake held");
        rdc(rcc_pkg::ADDR_IRQ_STATUS, 32'h1, 32'h1, "wake irq");
        @(posedge clk);
        radioPoweredUp <= 1'h1;
        #6010 rdc(CTL, 32'h100000, 32'h0, "wake clr");
        @(posedge clk);
        {coreOnMasterClk, deepSleepRequest} <= 2'h3;
        @(posedge clk);
        deepSleepRequest <= 1'h0;
        rdc(CTL, 32'h140, 32'h40, "pd early");
        #10010 rdc(CTL, 32'h140, 32'h140, "pd set");
        @(posedge clk);
        sleepExitInterrupt <= 1'h1;
        @(posedge clk);
        sleepExitInterrupt <= 1'h0;
        rdc(CTL, 32'h100, 32'h0, "pd clr");
        @(posedge clk);
        // dynamic value differs from every static value the loop leaves
        {staticPriority, dynamicPriority} <= 8'h5C;
        for (int k = 0; k < 3; k++) begin
            wr(CTL, {START, 5'h0, k == 0, k == 2, 15'h0});
            priorityValid <= (k == 0);
            eventInProcess <= 1'h1;
            waitRise(1100);
            if (k == 1) begin
                chk("no start", found, 1'h0);
                @(posedge clk);
                txRxEnable <= 1'h1;
                waitRise(4);
            end else begin
                chk("start", fineCounter, START + 10'h1);
            end
            chk("rise", found, 1'h1);
            @(posedge clk);
            staticPriority <= ~staticPriority;
            lows = 0;
            repeat (6) begin
                @(posedge clk);
                #1 lows += (radioTransactionSignal !== 1'h1);
            end
            chk("lows", lows, k == 0);
            @(posedge clk);
            {eventInProcess, txRxEnable} <= 2'h0;
            #201 chk("drop", radioTransactionSignal, 1'h0);
        end
        rdc(rcc_pkg::ADDR_IRQ_STATUS, 32'hA, 32'hA, "stat pd tx");
        wr(CTL, 32'h20000);
        #201 chk("dyn prio", arbiterPriority, 4'hC);
        wr(CTL, 32'h0);
        #201 chk("stat prio", arbiterPriority, staticPriority);
        report_and_stop();
    end
endmodule
